// ==== design/dcb_pkg.sv ====
package dcb_pkg;
	// command byte fields
	localparam int CMD_DIR_BIT = 6;
	// timing, in own units
	localparam int CLK_HZ = 40_000_000;
	localparam int DESEL_MAX_US = 20_000;
	localparam int WRDIS_MAX_NS = 1_000;
	localparam int INIT_MAX_S = 90;
	localparam int CLK_NS = 25;
	localparam int WRDIS_CYC = WRDIS_MAX_NS / CLK_NS;
	localparam int DESEL_CYC = DESEL_MAX_US * (CLK_HZ / 1_000_000);
	localparam longint INIT_CYC = longint'(INIT_MAX_S) * CLK_HZ;
	// reset values
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [7:0] PARAM_RST = 8'h00;
	// general_status field positions
	localparam int GS_LINK_ERR_BIT = 1;
	// sense byte 2 field positions
	localparam int SB2_INIT_BIT = 0;
	typedef enum logic [4:0] {
		DCB_IDLE  = 5'b00001,
		DCB_CACK  = 5'b00010,
		DCB_WPAR  = 5'b00100,
		DCB_PACK  = 5'b01000,
		DCB_SACK  = 5'b10000
	} dcb_state_e;
endpackage : dcb_pkg

// ==== design/dcb_port.sv ====
// Contract
// - bus lines active low both sides
// - direction line picks who drives bus
// - strobe means radial, requests mean byte mode
// - unit number from chosen bus line
// - dir+strobe: own line is selection
// - strobe without dir: drive service flag
// - byte mode is two handshaked bytes
// - command bit 6 picks parameter direction
// - direction mismatch sets flag and link error
// - first request while reading flags error
// - drive returns status byte on read
// - bus line zero is byte lsb
// - control lines active low
// - ignore protocol while interface inactive
// - deselect and disable write on inactive
// - reset on inactive, flag on return
// - initial state reached within ninety seconds
// - initial state clears parameters except spin
// - initial state clears errors, sets init bit
// - strobe edge selects or deselects unit
// - selected drive acknowledges selection
// - busy withholds command acknowledge
`timescale 1ns/1ps
`default_nettype none
module dcb_port
	import dcb_pkg::*;
#(
	parameter int UNIT     = 0,
	parameter int DESEL_N  = DESEL_CYC,
	parameter int STRICT   = 1
) (
	// clock and reset
	input  wire logic       sys_clk_i,
	input  wire logic       resetn_i,
	// shared control bus, active low
	input  wire logic [7:0] bus_n_i,
	output logic      [7:0] bus_n_o,
	output logic      [7:0] bus_n_oe_n_o,
	// host control lines, active low
	input  wire logic       radial_strobe_n_i,
	input  wire logic       first_byte_req_n_i,
	input  wire logic       second_byte_req_n_i,
	input  wire logic       host_to_device_dir_n_i,
	input  wire logic       interface_active_n_i,
	input  wire logic       write_gate_n_i,
	// device control lines, active low
	output logic            byte_handshake_ack_n_o,
	output logic            busy_n_o,
	// drive-side view
	input  wire logic       dev_busy_i,
	input  wire logic       service_req_i,
	input  wire logic       service_clear_i,
	input  wire logic       init_done_i,
	input  wire logic       unit_reset_cmd_i,
	input  wire logic [7:0] status_byte_i,
	output logic            selected_o,
	output logic            service_flag_o,
	output logic            write_enable_o,
	output logic            in_init_o,
	output logic            cmd_valid_o,
	output logic      [7:0] cmd_byte_o,
	output logic      [7:0] param_byte_o,
	output logic            param_valid_o,
	output logic            status_taken_o,
	output logic      [7:0] general_status_o,
	output logic      [7:0] sense2_o
);
	if (UNIT < 0 || UNIT > 7) begin : g_bad_unit
		$error("UNIT must be 0..7");
	end
	if (DESEL_N < 1) begin : g_bad_desel
		$error("DESEL_N must be at least 1");
	end

	// synchronised pins, inverted to active-high
	logic [7:0] bus_s;
	logic [5:0] ctl_s;
	dcb_sync #(.W(8), .RST(1'b1)) u_bus_sync (
		.sys_clk_i (sys_clk_i),
		.resetn_i  (resetn_i),
		.d_i       (bus_n_i),
		.q_o       (bus_s)
	);
	dcb_sync #(.W(6), .RST(1'b1)) u_ctl_sync (
		.sys_clk_i (sys_clk_i),
		.resetn_i  (resetn_i),
		.d_i       ({write_gate_n_i, interface_active_n_i,
		             host_to_device_dir_n_i, second_byte_req_n_i,
		             first_byte_req_n_i, radial_strobe_n_i}),
		.q_o       (ctl_s)
	);

	wire [7:0] bus_v   = ~bus_s;
	wire       strb    = ~ctl_s[0];
	wire       req1    = ~ctl_s[1];
	wire       req2    = ~ctl_s[2];
	wire       dir_out = ~ctl_s[3];
	wire       ifa     = ~ctl_s[4];
	wire       wgate   = ~ctl_s[5];

	logic            strb_d;
	logic            ifa_d;
	logic            sel;
	logic            svc;
	logic            sel_ack;
	logic            ack;
	logic            init;
	logic            pend_flag;
	logic [7:0]      cmd;
	logic [7:0]      par;
	logic [7:0]      gs;
	logic [7:0]      sb2;
	logic [7:0]      drv;
	logic [7:0]      oe;
	logic [31:0]     desel_cnt;
	dcb_state_e      st;
	dcb_state_e      next_st;

	wire live       = ifa;
	wire strb_rise  = live && strb && !strb_d;
	wire radial     = live && strb;
	wire my_line    = bus_v[UNIT];
	wire sel_edge   = strb_rise && dir_out;
	wire attn_mode  = radial && !dir_out;
	wire ifa_fall   = ifa_d && !ifa;
	wire init_reached = pend_flag && init_done_i && ifa;
	wire go_init    = ifa_fall || unit_reset_cmd_i;
	wire cmd_take   = st == DCB_IDLE && sel && live && req1 && dir_out
	                  && !dev_busy_i;
	wire bad_req1   = STRICT != 0 && st == DCB_IDLE && sel && live
	                  && req1 && !dir_out;
	wire par_out    = cmd[CMD_DIR_BIT];
	wire par_req    = st == DCB_WPAR && live && req2;
	wire dir_bad    = par_req && (dir_out != par_out);
	wire par_take   = par_req && !dir_bad && dir_out;
	wire stat_take  = par_req && !dir_bad && !dir_out;
	wire proto_err  = dir_bad || bad_req1;
	wire svc_set    = service_req_i || proto_err
	                  || init_reached;
	wire desel_due  = !ifa && desel_cnt >= 32'(DESEL_N - 1);

	// byte-transfer sequencer, four-phase handshake
	always_comb begin
		next_st = st;
		unique case (st)
			DCB_IDLE: if (cmd_take) next_st = DCB_CACK;
			DCB_CACK: if (!req1) next_st = DCB_WPAR;
			DCB_WPAR: begin
				if (par_take) next_st = DCB_PACK;
				else if (stat_take) next_st = DCB_SACK;
				else if (dir_bad) next_st = DCB_IDLE;
			end
			DCB_PACK: if (!req2) next_st = DCB_IDLE;
			DCB_SACK: if (!req2) next_st = DCB_IDLE;
			default:  next_st = DCB_IDLE;
		endcase
	end

	// bus drive: status byte or attention bit only
	always_comb begin
		drv = 8'hff;
		oe  = 8'hff;
		if (attn_mode) begin
			drv[UNIT] = !svc;
			oe[UNIT]  = 1'b0;
		end else if (st == DCB_SACK && sel && !dir_out) begin
			drv = ~status_byte_i;
			oe  = 8'h00;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			strb_d <= 1'b0;
			ifa_d  <= 1'b0;
		end else begin
			strb_d <= strb;
			ifa_d  <= ifa;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i || ifa) desel_cnt <= '0;
		else if (!desel_due) desel_cnt <= desel_cnt + 32'd1;
	end

	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) st <= DCB_IDLE;
		else if (!live || go_init) st <= DCB_IDLE;
		else st <= next_st;
	end

	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			sel     <= 1'b0;
			sel_ack <= 1'b0;
		end else if (go_init || desel_due) begin
			sel     <= 1'b0;
			sel_ack <= 1'b0;
		end else if (sel_edge) begin
			sel     <= my_line;
			sel_ack <= my_line;
		end else if (!strb) begin
			sel_ack <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) ack <= 1'b0;
		else if (!live || go_init) ack <= 1'b0;
		else ack <= next_st == DCB_CACK || next_st == DCB_PACK
		            || next_st == DCB_SACK;
	end

	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			init      <= 1'b1;
			pend_flag <= 1'b1;
		end else if (go_init) begin
			init      <= 1'b1;
			pend_flag <= 1'b1;
		end else begin
			if (init_done_i && ifa) init <= 1'b0;
			if (init_reached)
				pend_flag <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) svc <= 1'b0;
		else if (svc_set) svc <= 1'b1;
		else if (service_clear_i || go_init) svc <= 1'b0;
	end

	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i || go_init) begin
			cmd <= PARAM_RST;
			par <= PARAM_RST;
			gs  <= STATUS_RST;
			sb2 <= STATUS_RST;
			sb2[SB2_INIT_BIT] <= 1'b1;
		end else begin
			if (cmd_take) cmd <= bus_v;
			if (par_take) par <= bus_v;
			if (proto_err) gs[GS_LINK_ERR_BIT] <= 1'b1;
			else if (service_clear_i) gs[GS_LINK_ERR_BIT] <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			bus_n_o                <= 8'hff;
			bus_n_oe_n_o           <= 8'hff;
			byte_handshake_ack_n_o <= 1'b1;
			busy_n_o               <= 1'b1;
			write_enable_o         <= 1'b0;
			cmd_valid_o            <= 1'b0;
			param_valid_o          <= 1'b0;
			status_taken_o         <= 1'b0;
		end else begin
			bus_n_o                <= drv;
			bus_n_oe_n_o           <= oe;
			byte_handshake_ack_n_o <= !(ack || sel_ack);
			busy_n_o               <= !dev_busy_i;
			write_enable_o         <= ifa && sel && wgate;
			cmd_valid_o            <= cmd_take;
			param_valid_o          <= par_take;
			status_taken_o         <= stat_take;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			selected_o       <= 1'b0;
			service_flag_o   <= 1'b0;
			in_init_o        <= 1'b1;
			cmd_byte_o       <= PARAM_RST;
			param_byte_o     <= PARAM_RST;
			general_status_o <= STATUS_RST;
			sense2_o         <= STATUS_RST;
		end else begin
			selected_o       <= sel;
			service_flag_o   <= svc;
			in_init_o        <= init;
			cmd_byte_o       <= cmd;
			param_byte_o     <= par;
			general_status_o <= gs;
			sense2_o         <= sb2;
		end
	end
endmodule : dcb_port
`default_nettype wire

// ==== design/dcb_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser, reset value selectable
module dcb_sync #(
	parameter int      W   = 1,
	parameter logic    RST = 1'b1
) (
	input  wire logic         sys_clk_i,
	input  wire logic         resetn_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta;

	if (W < 1) begin : g_bad_w
		$error("W must be at least 1");
	end

	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			meta <= {W{RST}};
			q_o  <= {W{RST}};
		end else begin
			meta <= d_i;
			q_o  <= meta;
		end
	end
endmodule : dcb_sync
`default_nettype wire

// ==== testbench/dcb_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module dcb_host (
	// from the drive
	input  wire logic       clk_i,
	input  wire logic       ack_n_i,
	input  wire logic [7:0] bus_i,
	// host lines, active low
	output logic            stb_n_o,
	output logic            rq1_n_o,
	output logic            rq2_n_o,
	output logic            dir_n_o,
	output logic      [7:0] drv_n_o,
	output logic            oe_n_o
);
	initial begin
		{stb_n_o, rq1_n_o, rq2_n_o, dir_n_o, oe_n_o} = 5'h1f;
		drv_n_o = 8'hff;
	end
	task automatic wack(input logic v, output logic ok);
		int i;
		ok = 1'b0;
		for (i = 0; i < 64 && !ok; i++) begin
			@(posedge clk_i);
			ok = (ack_n_i === v);
		end
	endtask : wack
	// k: 0 strobe, 1 first byte, 2 second byte
	task automatic xfer(input int k, input logic o, input logic [7:0] d,
		output logic [7:0] q, output logic ok);
		logic ok2;
		@(posedge clk_i);
		dir_n_o <= !o;
		drv_n_o <= ~d;
		oe_n_o  <= !o;
		stb_n_o <= k != 0;
		rq1_n_o <= k != 1;
		rq2_n_o <= k != 2;
		wack(1'b0, ok);
		q = ~bus_i;
		{stb_n_o, rq1_n_o, rq2_n_o, oe_n_o} <= 4'hf;
		wack(1'b1, ok2);
		ok = ok & ok2;
	endtask : xfer
endmodule : dcb_host
`default_nettype wire

// ==== testbench/dcb_port_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module dcb_port_asserts (
	// watched pins
	input wire logic       sys_clk_i,
	input wire logic       resetn_i,
	input wire logic       interface_active_n_i,
	input wire logic       host_to_device_dir_n_i,
	input wire logic       radial_strobe_n_i,
	input wire logic       first_byte_req_n_i,
	input wire logic       second_byte_req_n_i,
	input wire logic       dev_busy_i,
	input wire logic       byte_handshake_ack_n_o,
	input wire logic [7:0] bus_n_oe_n_o,
	input wire logic       selected_o,
	input wire logic       write_enable_o,
	input wire logic       cmd_valid_o,
	input wire logic       status_taken_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);
	wire quiet = first_byte_req_n_i & second_byte_req_n_i
		& radial_strobe_n_i;
	a_read_release: assert property (
		(!host_to_device_dir_n_i)[*4] |-> bus_n_oe_n_o == 8'hff)
		else $error("bus driven in host direction");
	a_write_off: assert property (
		interface_active_n_i[*4] |-> !write_enable_o)
		else $error("write left on");
	a_idle_no_ack: assert property (
		interface_active_n_i[*6] |-> byte_handshake_ack_n_o)
		else $error("ack while port inactive");
	a_busy_no_cmd: assert property (
		dev_busy_i[*3] |-> !cmd_valid_o)
		else $error("command taken while busy");
	a_ack_release: assert property (
		quiet[*6] |-> byte_handshake_ack_n_o)
		else $error("ack held without request");
	a_cmd_ack: assert property (
		cmd_valid_o |=> !byte_handshake_ack_n_o)
		else $error("command without ack");
	a_sel_ack: assert property (
		$rose(selected_o) |-> !byte_handshake_ack_n_o)
		else $error("selection without ack");
	a_dir_in_cmd: assert property (
		host_to_device_dir_n_i[*6] |-> !cmd_valid_o)
		else $error("command taken with dir in");
	a_stat_drive: assert property (
		status_taken_o |=> bus_n_oe_n_o == 8'h00)
		else $error("status byte not driven");
endmodule : dcb_port_asserts
bind dcb_port dcb_port_asserts u_dcb_port_asserts (.sys_clk_i, .resetn_i,
	.interface_active_n_i, .host_to_device_dir_n_i, .radial_strobe_n_i,
	.first_byte_req_n_i, .second_byte_req_n_i, .dev_busy_i,
	.byte_handshake_ack_n_o, .bus_n_oe_n_o, .selected_o, .write_enable_o,
	.cmd_valid_o, .status_taken_o);
`default_nettype wire

// ==== testbench/dcb_port_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module dcb_port_test;
	import dcb_pkg::*;
	logic       sys_clk_i, resetn_i, interface_active_n_i, write_gate_n_i;
	logic       dev_busy_i, service_req_i, service_clear_i, init_done_i;
	logic       unit_reset_cmd_i, ok;
	logic [7:0] status_byte_i, q;
	int         errors, compares;
	wire logic       radial_strobe_n_i, first_byte_req_n_i, h_oe_n;
	wire logic       second_byte_req_n_i, host_to_device_dir_n_i;
	wire logic       byte_handshake_ack_n_o, busy_n_o, selected_o;
	wire logic       service_flag_o, write_enable_o, in_init_o;
	wire logic       cmd_valid_o, param_valid_o, status_taken_o;
	wire logic [7:0] bus_n_i, bus_n_o, bus_n_oe_n_o, h_drv, cmd_byte_o;
	wire logic [7:0] param_byte_o, general_status_o, sense2_o;
	wire logic [1:0] err_v = {general_status_o[GS_LINK_ERR_BIT],
		service_flag_o};
	wire logic [3:0] init_v = {selected_o, write_enable_o, in_init_o,
		sense2_o[SB2_INIT_BIT]};
	int         n_cmd, n_par, n_stat;
	// host pull-up: a released line reads high
	assign bus_n_i = h_oe_n ? (bus_n_o | bus_n_oe_n_o) : h_drv;
	dcb_port #(.UNIT(0), .DESEL_N(8), .STRICT(1)) u_dcb_port (.sys_clk_i,
		.resetn_i, .bus_n_i, .bus_n_o, .bus_n_oe_n_o, .radial_strobe_n_i,
		.first_byte_req_n_i, .second_byte_req_n_i, .host_to_device_dir_n_i,
		.interface_active_n_i, .write_gate_n_i, .byte_handshake_ack_n_o,
		.busy_n_o, .dev_busy_i, .service_req_i, .service_clear_i,
		.init_done_i, .unit_reset_cmd_i, .status_byte_i, .selected_o,
		.service_flag_o, .write_enable_o, .in_init_o, .cmd_valid_o,
		.cmd_byte_o, .param_byte_o, .param_valid_o, .status_taken_o,
		.general_status_o, .sense2_o);
	dcb_host u_dcb_host (.clk_i(sys_clk_i), .ack_n_i(byte_handshake_ack_n_o),
		.bus_i(bus_n_i), .stb_n_o(radial_strobe_n_i),
		.rq1_n_o(first_byte_req_n_i), .rq2_n_o(second_byte_req_n_i),
		.dir_n_o(host_to_device_dir_n_i), .drv_n_o(h_drv), .oe_n_o(h_oe_n));
	task automatic chk(input logic [15:0] s, e);
		compares++;
		if (s !== e) begin
			errors++;
			$display("mismatch %0t %h %h", $time, s, e);
		end
	endtask : chk
	task automatic hs(input int k, input logic o, input logic [7:0] d);
		u_dcb_host.xfer(k, o, d, q, ok);
	endtask : hs
	// w: bit0 clear, bit1 service request, bit2 selective reset
	task automatic pulse(input logic [2:0] w);
		@(posedge sys_clk_i);
		{unit_reset_cmd_i, service_req_i, service_clear_i} <= w;
		@(posedge sys_clk_i);
		{unit_reset_cmd_i, service_req_i, service_clear_i} <= 3'h0;
	endtask : pulse
	// one-cycle pulses, counted where they are settled
	always @(negedge sys_clk_i) begin
		if (cmd_valid_o === 1'b1) n_cmd++;
		if (param_valid_o === 1'b1) n_par++;
		if (status_taken_o === 1'b1) n_stat++;
	end
	task automatic results;
		if (errors == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : results
	task automatic t_select;
		hs(0, 1'b1, 8'h02);
		chk(16'({ok, selected_o}), 16'h0000);
		hs(0, 1'b1, 8'h01);
		chk(16'({ok, selected_o}), 16'h0003);
	endtask : t_select
	task automatic t_bytes;
		write_gate_n_i <= 1'b0;
		hs(1, 1'b1, 8'h45);
		chk(16'({ok, cmd_byte_o}), 16'h0145);
		hs(2, 1'b1, 8'h3c);
		chk(16'({ok, write_enable_o, param_byte_o}), 16'h033c);
		hs(1, 1'b1, 8'h05);
		chk(16'({ok, cmd_byte_o}), 16'h0105);
		hs(2, 1'b0, 8'h00);
		chk(16'({ok, q}), 16'h01a6);
		chk(16'(bus_n_i), 16'h00ff);
	endtask : t_bytes
	task automatic t_errors;
		hs(1, 1'b1, 8'h45);
		chk(16'(ok), 16'h0001);
		hs(2, 1'b0, 8'h00);
		chk(16'({ok, err_v}), 16'h0003);
		pulse(3'h1);
		repeat (2) @(posedge sys_clk_i);
		chk(16'(err_v), 16'h0000);
		hs(1, 1'b0, 8'h45);
		chk(16'({ok, err_v}), 16'h0003);
		pulse(3'h1);
	endtask : t_errors
	task automatic t_busy;
		dev_busy_i <= 1'b1;
		fork
			hs(1, 1'b1, 8'h45);
			begin
				repeat (30) @(posedge sys_clk_i);
				chk(16'({byte_handshake_ack_n_o, busy_n_o}), 16'h0002);
				dev_busy_i <= 1'b0;
			end
		join
		chk(16'(ok), 16'h0001);
		hs(2, 1'b1, 8'h11);
		chk(16'({ok, param_byte_o}), 16'h0111);
	endtask : t_busy
	task automatic t_attention;
		pulse(3'h1);
		hs(0, 1'b0, 8'h00);
		chk(16'(q), 16'h0000);
		pulse(3'h2);
		hs(0, 1'b0, 8'h00);
		chk(16'(q), 16'h0001);
	endtask : t_attention
	task automatic t_inactive;
		init_done_i <= 1'b0;
		interface_active_n_i <= 1'b1;
		repeat (16) @(posedge sys_clk_i);
		chk(16'(init_v), 16'h0003);
		hs(1, 1'b1, 8'h45);
		chk(16'(ok), 16'h0000);
		interface_active_n_i <= 1'b0;
		pulse(3'h1);
		init_done_i <= 1'b1;
		repeat (8) @(posedge sys_clk_i);
		chk(16'({in_init_o, service_flag_o}), 16'h0001);
		hs(0, 1'b1, 8'h01);
		chk(16'({ok, selected_o}), 16'h0003);
		pulse(3'h4);
		repeat (6) @(posedge sys_clk_i);
		chk(16'({selected_o, in_init_o}), 16'h0000);
	endtask : t_inactive
	task automatic t_count;
		chk(16'({n_cmd[3:0], n_par[3:0], n_stat[3:0]}), 16'h0421);
	endtask : t_count
	initial begin
		sys_clk_i = 1'b0;
		forever #12.5 sys_clk_i = ~sys_clk_i;
	end
	initial begin
		{resetn_i, interface_active_n_i, dev_busy_i} = 3'h0;
		{service_req_i, service_clear_i, unit_reset_cmd_i} = 3'h0;
		{write_gate_n_i, init_done_i} = 2'h3;
		status_byte_i = 8'ha6;
		repeat (10) @(posedge sys_clk_i);
		resetn_i <= 1'b1;
		repeat (8) @(posedge sys_clk_i);
		t_select;
		t_bytes;
		t_errors;
		t_busy;
		t_attention;
		t_inactive;
		t_count;
		results;
	end
	initial begin
		repeat (30000) @(posedge sys_clk_i);
		errors++;
		results;
	end
endmodule : dcb_port_test
`default_nettype wire
